// ### rtl/scs_pkg.sv
// Constants, register map and state codes of the system clock source and start-up block.
// Assumes one 10 MHz clock and an APB master with 32-bit data.
`default_nettype none
package scs_pkg;
  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [11:0] OFF_OSC_TRIM   = 12'h000;
  localparam logic [11:0] OFF_DIV_CTRL   = 12'h004;
  localparam logic [11:0] OFF_TIMER_CTRL = 12'h008;
  localparam logic [11:0] OFF_STATUS     = 12'h00C;
  localparam int unsigned BIT_UNLOCK     = 7;
  localparam int unsigned BIT_TIMER_EXT  = 0;
  localparam logic [7:0]  TIMER_CTRL_RST = 8'h00;
  // ****************************************************************
  // Fuse codes and divider.
  // ****************************************************************
  localparam logic [3:0]  SRC_CODE_RC    = 4'h2;
  localparam logic [3:0]  SRC_CODE_EXT   = 4'h0;
  localparam logic [1:0]  SUT_CODE_14    = 2'h0;
  localparam logic [1:0]  SUT_CODE_SHORT = 2'h1;
  localparam logic [1:0]  SUT_CODE_LONG  = 2'h2;
  localparam logic [1:0]  SUT_CODE_RSVD  = 2'h3;
  localparam logic [3:0]  DIV_SEL_MAX    = 4'h8;
  localparam logic [3:0]  DIV_SEL_BOOT8  = 4'h3;
  localparam logic [3:0]  DIV_SEL_NONE   = 4'h0;
  // ****************************************************************
  // Counts of cycles.
  // ****************************************************************
  localparam logic [16:0] RST_BASE_CK    = 17'h0_000E;
  localparam logic [16:0] WAKE_CK        = 17'h0_0006;
  localparam logic [1:0]  UNLOCK_CYC     = 2'h3;
  localparam int unsigned RST_SHORT_WDT  = 4096;
  localparam int unsigned RST_LONG_WDT   = 65536;
  localparam logic [15:0] RC_BASE_INC    = 16'h2000;
  // ****************************************************************
  // Start-up states.
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_RESET   = 3'b000,
    ST_BASE    = 3'b001,
    ST_TIMEOUT = 3'b010,
    ST_RUN     = 3'b011,
    ST_SLEEP   = 3'b100,
    ST_WAKE    = 3'b101
  } scs_state_e;
endpackage : scs_pkg
`default_nettype wire

// ### rtl/scs_pin_sync.sv
// Three-stage synchroniser with agreement filter and rising-edge pulse for one pin.
// Assumes the pin is asynchronous to clk_i and slower than half its rate.
`default_nettype none
module scs_pin_sync (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  logic rise_ff;

  always_ff @(posedge clk_i) begin
    s1_ff <= pin_i;
    s2_ff <= s1_ff;
    s3_ff <= s2_ff;
  end

  // A change counts only once the second and third stages agree.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      level_ff <= 1'b0;
      rise_ff  <= 1'b0;
    end else begin
      rise_ff <= 1'b0;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
        rise_ff  <= s3_ff & ~level_ff;
      end
    end
  end

  assign level_o = level_ff;
  assign rise_o  = rise_ff;
endmodule // scs_pin_sync
`default_nettype wire

// ### rtl/scs_clock_ctrl.sv
// System clock source selection, start-up sequencing, prescaler and clock output with an APB slave.
// Assumes fuses are static levels, tick inputs are one-cycle pulses on clk_i, and pins are asynchronous.
`default_nettype none
module scs_clock_ctrl
  import scs_pkg::*;
#(
  parameter int unsigned RST_SHORT_WDT_CYC = RST_SHORT_WDT,
  parameter int unsigned RST_LONG_WDT_CYC  = RST_LONG_WDT
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [3:0]  clock_source_select_fuses_i,
  input  wire logic [1:0]  startup_time_fuses_i,
  input  wire logic        boot_divide_by_eight_fuse_i,
  input  wire logic        clock_out_fuse_i,
  input  wire logic [7:0]  cal_byte_i,
  input  wire logic        wdt_osc_tick_i,
  input  wire logic        sleep_req_i,
  input  wire logic        wake_i,
  input  wire logic        crystal_input_pin_i,
  input  wire logic        timer_osc_input_pin_i,
  input  wire logic        io_out_i,
  input  wire logic        io_oe_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             sys_clk_tick_o,
  output logic             cpu_run_o,
  output logic [6:0]       trim_value_o,
  output logic             clock_output_pin_o,
  output logic             clock_output_pin_oe_o,
  output logic             timer_osc_output_pin_o,
  output logic             timer_osc_output_pin_oe_o,
  output logic             timer_clock_tick_o
);
  // ****************************************************************
  // Parameter checks and helpers.
  // ****************************************************************
  // The time-out counter is 17 bits wide, so larger counts cannot be served.
  if (RST_SHORT_WDT_CYC == 0 || RST_SHORT_WDT_CYC > 131071 ||
      RST_LONG_WDT_CYC == 0 || RST_LONG_WDT_CYC > 131071) begin : g_bad_counts
    $error("time-out counts must lie between 1 and 131071");
  end

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr[11:2] == off[11:2]);
  endfunction

  function automatic logic [7:0] div_limit(input logic [3:0] sel);
    logic [8:0] f;
    f = 9'h001 << sel;
    div_limit = 8'(f - 9'h001);
  endfunction

  // ****************************************************************
  // Fuse capture.
  // ****************************************************************
  logic       src_ext_ff;
  logic [1:0] sut_ff;
  logic       clock_out_fuse_ff;
  logic       boot8_ff;
  logic       fuse_bad_ff;

  // Fuses are only looked at while reset is active, so a fuse change in operation has no effect.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      src_ext_ff  <= (clock_source_select_fuses_i == SRC_CODE_EXT);
      sut_ff      <= startup_time_fuses_i;
      clock_out_fuse_ff    <= clock_out_fuse_i;
      boot8_ff    <= boot_divide_by_eight_fuse_i;
      fuse_bad_ff <= (startup_time_fuses_i == SUT_CODE_RSVD) ||
                     ((clock_source_select_fuses_i != SRC_CODE_RC) &&
                      (clock_source_select_fuses_i != SRC_CODE_EXT));
    end
  end

  // ****************************************************************
  // APB slave.
  // ****************************************************************
  logic [7:0]  trim_ff;
  logic [3:0]  div_sel_ff;
  logic        unlock_ff;
  logic [1:0]  unlock_cnt_ff;
  logic [7:0]  timer_ctrl_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic        wr_go;
  logic        mapped;
  logic        div_wr;
  logic        unlock_req;
  logic        sel_req;
  scs_state_e  state_ff;

  assign mapped     = hit(paddr_i, OFF_OSC_TRIM) || hit(paddr_i, OFF_DIV_CTRL) ||
                      hit(paddr_i, OFF_TIMER_CTRL) || hit(paddr_i, OFF_STATUS);
  assign wr_go      = psel_i & penable_i & pwrite_i & pstrb_i[0];
  assign div_wr     = wr_go & hit(paddr_i, OFF_DIV_CTRL);
  assign unlock_req = div_wr & pwdata_i[BIT_UNLOCK] & (pwdata_i[6:0] == 7'h00);
  assign sel_req    = div_wr & ~pwdata_i[BIT_UNLOCK] & unlock_ff & (pwdata_i[3:0] <= DIV_SEL_MAX);

  // The calibration byte is reloaded on every reset cycle.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      trim_ff <= cal_byte_i;
    end else if (wr_go && hit(paddr_i, OFF_OSC_TRIM)) begin
      trim_ff <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_sel_ff <= boot_divide_by_eight_fuse_i ? DIV_SEL_BOOT8 : DIV_SEL_NONE;
    end else if (sel_req) begin
      div_sel_ff <= pwdata_i[3:0];
    end
  end

  // A repeated unlock write neither extends nor cancels the open window.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      unlock_ff     <= 1'b0;
      unlock_cnt_ff <= 2'h0;
    end else if (!unlock_ff) begin
      if (unlock_req) begin
        unlock_ff     <= 1'b1;
        unlock_cnt_ff <= UNLOCK_CYC;
      end
    end else if (sel_req || unlock_cnt_ff == 2'h0) begin
      unlock_ff <= 1'b0;
    end else begin
      unlock_cnt_ff <= unlock_cnt_ff - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      timer_ctrl_ff <= TIMER_CTRL_RST;
    end else if (wr_go && hit(paddr_i, OFF_TIMER_CTRL)) begin
      timer_ctrl_ff <= {7'h00, pwdata_i[BIT_TIMER_EXT]};
    end
  end

  // Read data is fetched in the setup cycle so the access phase completes without wait states.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (psel_i && !penable_i) begin
      pslverr_ff <= ~mapped;
      prdata_ff  <= 32'h0000_0000;
      if (hit(paddr_i, OFF_OSC_TRIM)) begin
        prdata_ff <= {24'h00_0000, trim_ff};
      end else if (hit(paddr_i, OFF_DIV_CTRL)) begin
        prdata_ff <= {24'h00_0000, unlock_ff, 3'h0, div_sel_ff};
      end else if (hit(paddr_i, OFF_TIMER_CTRL)) begin
        prdata_ff <= {24'h00_0000, timer_ctrl_ff};
      end else if (hit(paddr_i, OFF_STATUS)) begin
        prdata_ff <= {20'h0_0000, 1'b0, state_ff, 1'b0, fuse_bad_ff, sut_ff, boot8_ff, clock_out_fuse_ff,
                      ~src_ext_ff, src_ext_ff};
      end
    end
  end

  assign prdata_o  = prdata_ff;
  assign pready_o  = 1'b1;
  assign pslverr_o = pslverr_ff & psel_i & penable_i;

  // ****************************************************************
  // Clock sources.
  // ****************************************************************
  logic [15:0] rc_acc_ff = 16'h0000;
  logic        rc_tick_ff = 1'b0;
  logic [16:0] rc_sum;
  logic        xtal_rise;
  logic        tosc_level;
  logic        tosc_rise;
  logic        src_tick;

  // The RC model runs through reset so the clock pin keeps toggling; its step grows with the trim.
  assign rc_sum = {1'b0, rc_acc_ff} + {1'b0, RC_BASE_INC} + {4'h0, trim_ff[6:0], 6'h00};

  always_ff @(posedge clk_i) begin
    rc_acc_ff  <= rc_sum[15:0];
    rc_tick_ff <= rc_sum[16];
  end

  scs_pin_sync u_xtal_sync (
    .clk_i   (clk_i),
    .reset_i (1'b0),
    .pin_i   (crystal_input_pin_i),
    .level_o (),
    .rise_o  (xtal_rise)
  );

  scs_pin_sync u_tosc_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   (timer_osc_input_pin_i),
    .level_o (tosc_level),
    .rise_o  (tosc_rise)
  );

  assign src_tick = src_ext_ff ? xtal_rise : rc_tick_ff;

  // ****************************************************************
  // Prescaler and clock output.
  // ****************************************************************
  logic [7:0] div_cnt_ff = 8'h00;
  logic       sys_tick_ff = 1'b0;
  logic       clock_output_pin_ff = 1'b0;
  logic       div_end;

  // Comparing with at-or-above keeps a shrinking factor from running the counter the long way round.
  assign div_end = (div_cnt_ff >= div_limit(div_sel_ff));

  always_ff @(posedge clk_i) begin
    sys_tick_ff <= src_tick & div_end;
    if (src_tick) begin
      div_cnt_ff <= div_end ? 8'h00 : div_cnt_ff + 8'h01;
    end
    if (sys_tick_ff) begin
      clock_output_pin_ff <= ~clock_output_pin_ff;
    end
  end

  assign sys_clk_tick_o        = sys_tick_ff & cpu_run_o;
  assign clock_output_pin_o    = clock_out_fuse_ff ? clock_output_pin_ff : io_out_i;
  assign clock_output_pin_oe_o = clock_out_fuse_ff | io_oe_i;
  assign trim_value_o          = trim_ff[6:0];

  // ****************************************************************
  // Timer oscillator pins.
  // ****************************************************************
  logic tosc_out_ff;
  logic ttick_ff;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tosc_out_ff <= 1'b0;
      ttick_ff    <= 1'b0;
    end else begin
      tosc_out_ff <= ~tosc_level;
      ttick_ff    <= tosc_rise & ~src_ext_ff;
    end
  end

  assign timer_osc_output_pin_o    = tosc_out_ff;
  assign timer_osc_output_pin_oe_o = ~src_ext_ff & ~timer_ctrl_ff[BIT_TIMER_EXT] & ~reset_i;
  assign timer_clock_tick_o        = ttick_ff;

  // ****************************************************************
  // Start-up sequencer.
  // ****************************************************************
  logic [16:0] cnt_ff;
  logic [16:0] tmo_limit;

  always_comb begin
    tmo_limit = 17'h0_0000;
    if (sut_ff == SUT_CODE_SHORT) begin
      tmo_limit = 17'(RST_SHORT_WDT_CYC);
    end else if (sut_ff == SUT_CODE_LONG) begin
      tmo_limit = 17'(RST_LONG_WDT_CYC);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= ST_RESET;
      cnt_ff   <= 17'h0_0000;
    end else begin
      unique case (state_ff)
        ST_RESET: begin
          state_ff <= ST_BASE;
          cnt_ff   <= 17'h0_0000;
        end
        ST_BASE: begin
          if (src_tick) begin
            cnt_ff <= cnt_ff + 17'h0_0001;
            if (cnt_ff == RST_BASE_CK - 17'h0_0001) begin
              cnt_ff   <= 17'h0_0000;
              state_ff <= (tmo_limit == 17'h0_0000) ? ST_RUN : ST_TIMEOUT;
            end
          end
        end
        ST_TIMEOUT: begin
          if (wdt_osc_tick_i) begin
            cnt_ff <= cnt_ff + 17'h0_0001;
            if (cnt_ff == tmo_limit - 17'h0_0001) begin
              state_ff <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (sleep_req_i) begin
            state_ff <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          cnt_ff <= 17'h0_0000;
          if (wake_i) begin
            state_ff <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (src_tick) begin
            cnt_ff <= cnt_ff + 17'h0_0001;
            if (cnt_ff == WAKE_CK - 17'h0_0001) begin
              state_ff <= ST_RUN;
            end
          end
        end
        default: begin
          state_ff <= ST_RESET;
        end
      endcase
    end
  end

  assign cpu_run_o = (state_ff == ST_RUN);

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_trim_reset_load: assert property (disable iff (1'b0)
    reset_i |=> trim_ff == $past(cal_byte_i)) else $error("trim not loaded from calibration byte");
  chk_div_reset_value: assert property (
    $fell(reset_i) |-> div_sel_ff == (boot8_ff ? DIV_SEL_BOOT8 : DIV_SEL_NONE))
    else $error("divide select wrong after reset");
  chk_unlock_expiry: assert property (
    $rose(unlock_ff) |-> ##4 !unlock_ff) else $error("unlock bit outlived its window");
  chk_sel_needs_unlock: assert property (
    !$past(reset_i) && $changed(div_sel_ff) |-> $past(unlock_ff) && !unlock_ff)
    else $error("divide select changed without unlock");
  chk_sel_not_reserved: assert property (
    div_sel_ff <= DIV_SEL_MAX) else $error("reserved divide select stored");
  chk_clock_output_pin_override: assert property (
    clock_out_fuse_ff |-> clock_output_pin_oe_o && clock_output_pin_o == clock_output_pin_ff)
    else $error("clock output not driven");
  chk_clock_output_pin_in_reset: assert property (disable iff (1'b0)
    reset_i && clock_out_fuse_i ##1 reset_i |-> clock_output_pin_oe_o)
    else $error("clock output idle during reset");
  chk_clock_output_pin_divided: assert property (
    !$past(reset_i) && $changed(clock_output_pin_ff) |-> $past(sys_tick_ff)) else $error("clock output not from divider");
  chk_wake_six_ck: assert property (
    $rose(cpu_run_o) && $past(state_ff) == ST_WAKE |-> $past(cnt_ff) == WAKE_CK - 17'h0_0001)
    else $error("wake did not take six source cycles");
  chk_timer_osc_gate: assert property (
    timer_clock_tick_o |-> !src_ext_ff) else $error("timer clock with external source");
  chk_fuse_hold: assert property (
    !$past(reset_i) |-> $stable(src_ext_ff) && $stable(sut_ff) && $stable(clock_out_fuse_ff))
    else $error("fuse sample changed in operation");
endmodule // scs_clock_ctrl
`default_nettype wire

// ### tb/scs_ext_src.sv
// Model of an external clock source that drives one oscillator pin.
// Assumes the bench changes the half period only while the device is held in reset.
`default_nettype none
module scs_ext_src (
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic [7:0] half_i,
  output logic            pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************************
  // Source.
  // ********************************
  logic [7:0] cnt_ff = 8'h00;
  logic       lvl_ff = 1'b0;
  // A stopped source parks low, as the pin is pulled down off the board.
  always_ff @(posedge clk_i) begin
    if (!run_i) begin
      cnt_ff <= 8'h00;
      lvl_ff <= 1'b0;
    end else if (cnt_ff >= half_i - 8'h01) begin
      cnt_ff <= 8'h00;
      lvl_ff <= ~lvl_ff;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  assign pin_o = lvl_ff;
endmodule // scs_ext_src
`default_nettype wire

// ### tb/tb_system_clock_source_and_startup.sv
// Self-checking bench for the clock source, start-up and prescaler block.
// Assumes the package, the design and the source model are compiled first.
`default_nettype none
`define CHK(nm, x, g) begin samples_checked++; if ((g) !== (x)) begin bad_count++; \
  $display("wrong value %s expected %0h seen %0h", nm, x, g); end end
module tb_system_clock_source_and_startup
  import scs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [3:0]  clock_source_select_fuses_i = SRC_CODE_RC;
  logic [1:0]  startup_time_fuses_i = SUT_CODE_SHORT;
  logic        boot_divide_by_eight_fuse_i = 1'b1;
  logic        clock_out_fuse_i = 1'b1;
  logic [7:0]  cal_byte_i = 8'hA5;
  logic        wdt_osc_tick_i = 1'b0;
  logic        sleep_req_i = 1'b0;
  logic        wake_i = 1'b0;
  logic        crystal_input_pin_i;
  logic        timer_osc_input_pin_i;
  logic        io_out_i = 1'b1;
  logic        io_oe_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [3:0]  pstrb_i = 4'hF;
  logic [31:0] prdata_o;
  logic [6:0]  trim_value_o;
  logic        pready_o, pslverr_o, sys_clk_tick_o, cpu_run_o, clock_output_pin_o, clock_output_pin_oe_o;
  logic        timer_osc_output_pin_o, timer_osc_output_pin_oe_o, timer_clock_tick_o;
  logic        wdt_en = 1'b0;
  logic        xtal_run = 1'b0;
  logic [31:0] rd;
  logic        er;
  int          tk, tg, tt, tq;
  int          cyc = 0;
  int          bad_count = 0;
  int          samples_checked = 0;

  // Small time-out counts keep the reset delays short.
  scs_clock_ctrl #(.RST_SHORT_WDT_CYC(4), .RST_LONG_WDT_CYC(8)) scs_clock_ctrl_i (
    .clk_i, .reset_i, .clock_source_select_fuses_i, .startup_time_fuses_i, .boot_divide_by_eight_fuse_i,
    .clock_out_fuse_i, .cal_byte_i, .wdt_osc_tick_i, .sleep_req_i, .wake_i, .crystal_input_pin_i,
    .timer_osc_input_pin_i, .io_out_i, .io_oe_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .sys_clk_tick_o, .cpu_run_o, .trim_value_o,
    .clock_output_pin_o, .clock_output_pin_oe_o, .timer_osc_output_pin_o, .timer_osc_output_pin_oe_o,
    .timer_clock_tick_o);
  scs_ext_src xtal_src_i (.clk_i, .run_i(xtal_run), .half_i(8'h0A), .pin_o(crystal_input_pin_i));
  scs_ext_src tosc_src_i (.clk_i, .run_i(1'b1), .half_i(8'h08), .pin_o(timer_osc_input_pin_i));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // The watchdog oscillator ticks every fourth cycle; the ceiling cuts a hang short.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    wdt_osc_tick_i <= wdt_en && (cyc % 4 == 0);
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  function automatic logic near(input int v, input int e, input int t);
    return (v >= e - t) && (v <= e + t);
  endfunction

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    pstrb_i  <= {4{w}};
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK("read data", x, rd)
  endtask

  task automatic count(input int n);
    logic p;
    logic q;
    p  = clock_output_pin_o;
    q  = timer_osc_output_pin_o;
    tk = 0;
    tg = 0;
    tt = 0;
    tq = 0;
    repeat (n) begin
      @(posedge clk_i);
      tk += int'(sys_clk_tick_o);
      tt += int'(timer_clock_tick_o);
      tg += int'(clock_output_pin_o !== p);
      tq += int'(timer_osc_output_pin_o !== q);
      p  = clock_output_pin_o;
      q  = timer_osc_output_pin_o;
    end
  endtask

  task automatic rst(input int n);
    reset_i <= 1'b1;
    count(n);
    reset_i <= 1'b0;
  endtask

  task automatic wait_run(input int lim);
    int n;
    n = 0;
    while (cpu_run_o !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("cpu run", 1'b1, cpu_run_o)
  endtask

  task automatic nap(input int lo, input int lim);
    sleep_req_i <= 1'b1;
    @(posedge clk_i);
    sleep_req_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK("run asleep", 1'b0, cpu_run_o)
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    repeat (lo) @(posedge clk_i);
    `CHK("run early", 1'b0, cpu_run_o)
    wait_run(lim);
  endtask

  // ********************************
  // Tests.
  // ********************************
  initial begin
    rst(4);
    repeat (300) @(posedge clk_i);
    `CHK("run without wdt", 1'b0, cpu_run_o)
    wdt_en <= 1'b1;
    wait_run(400);
    clock_out_fuse_i <= 1'b0;
    rc(OFF_STATUS, {21'h0, ST_RUN, 8'h1E});
    rc(OFF_OSC_TRIM, 32'h0000_00A5);
    `CHK("trim out", 7'h25, trim_value_o)
    rc(OFF_DIV_CTRL, 32'h0000_0003);
    rc(OFF_TIMER_CTRL, 32'h0000_0000);
    rc(12'h010, 32'h0000_0000);
    `CHK("slave error", 1'b1, er)
    // The late select write lands after the unlock window has closed.
    xfer(1'b1, OFF_DIV_CTRL, 32'h0000_0005);
    xfer(1'b1, OFF_DIV_CTRL, 32'h0000_0080);
    rc(OFF_DIV_CTRL, 32'h0000_0083);
    xfer(1'b1, OFF_DIV_CTRL, 32'h0000_0005);
    rc(OFF_DIV_CTRL, 32'h0000_0003);
    xfer(1'b1, OFF_DIV_CTRL, 32'h0000_0081);
    xfer(1'b1, OFF_DIV_CTRL, 32'h0000_0000);
    rc(OFF_DIV_CTRL, 32'h0000_0003);
    xfer(1'b1, OFF_DIV_CTRL, 32'h0000_0080);
    xfer(1'b1, OFF_DIV_CTRL, 32'h0000_0009);
    rc(OFF_DIV_CTRL, 32'h0000_0003);
    xfer(1'b1, OFF_OSC_TRIM, 32'h0000_0000);
    for (int s = 8; s >= 0; s--) begin
      xfer(1'b1, OFF_DIV_CTRL, 32'h0000_0080);
      xfer(1'b1, OFF_DIV_CTRL, 32'(s));
      rc(OFF_DIV_CTRL, 32'(s));
      if (s < 4) begin
        count(1024);
        `CHK("rc ticks", 1'b1, near(tk, 128 >> s, 2))
        `CHK("pin toggles", 1'b1, near(tg, tk, 1))
        `CHK("pin enable", 1'b1, clock_output_pin_oe_o)
      end
    end
    // No memory write runs during this test, so the top trim code is allowed here.
    xfer(1'b1, OFF_OSC_TRIM, 32'h0000_007F);
    count(1024);
    `CHK("fast trim ticks", 1'b1, near(tk, 255, 2))
    `CHK("timer pin toggles", 1'b1, near(tq, 128, 2))
    `CHK("timer ticks", 1'b1, near(tt, 64, 2))
    `CHK("timer pin enable", 1'b1, timer_osc_output_pin_oe_o)
    xfer(1'b1, OFF_TIMER_CTRL, 32'h0000_0001);
    rc(OFF_TIMER_CTRL, 32'h0000_0001);
    `CHK("timer pin enable", 1'b0, timer_osc_output_pin_oe_o)
    xfer(1'b1, OFF_OSC_TRIM, 32'h0000_0000);
    nap(38, 40);
    clock_source_select_fuses_i <= SRC_CODE_EXT;
    startup_time_fuses_i        <= SUT_CODE_14;
    boot_divide_by_eight_fuse_i <= 1'b0;
    xtal_run                    <= 1'b1;
    rst(8);
    repeat (260) @(posedge clk_i);
    `CHK("run before 14 ticks", 1'b0, cpu_run_o)
    wait_run(1000);
    rc(OFF_DIV_CTRL, 32'h0000_0000);
    rc(OFF_STATUS, {21'h0, ST_RUN, 8'h01});
    `CHK("timer pin enable", 1'b0, timer_osc_output_pin_oe_o)
    `CHK("io pin", 1'b1, clock_output_pin_o)
    io_out_i <= 1'b0;
    count(2000);
    `CHK("io pin", 1'b0, clock_output_pin_o)
    `CHK("ext ticks", 1'b1, near(tk, 100, 2))
    `CHK("ext timer ticks", 0, tt)
    nap(80, 200);
    clock_out_fuse_i     <= 1'b1;
    startup_time_fuses_i <= SUT_CODE_RSVD;
    rst(100);
    `CHK("toggles in reset", 1'b1, tg > 1)
    `CHK("pin enable in reset", 1'b1, clock_output_pin_oe_o)
    wait_run(1000);
    rc(OFF_STATUS, {21'h0, ST_RUN, 8'h75});
    close_out();
  end
endmodule // tb_system_clock_source_and_startup
`default_nettype wire
